// ---- design/amp_dac_control_regs.sv ----
// control register bank for the amplifier, sense path and converter
// assumes the register port and the converter sample strobe are on clk
// How it works
// - sense rate is converter rate over 1/2/4/8
// - bit 3 enables sense high-pass, on at reset
// - bit 2 selects slow low-emission edge_rate_select
// - bit 0 picks 3.6 V or 5.2 V mapping
// - bit 7 clear ramps level, set jumps
// - bit 5 enables converter high-pass, on at reset
// - bit 4 low power: 64x, else 128x
// - rate range codes 000-100; others are stored but keep the last legal range
// - code 0x00 +24 dB, 0x40 0 dB, 0.375 steps
// - code 0xFE -71.25 dB, 0xFF full mute
`default_nettype none
module amp_dac_control_regs
#(
  parameter int RAMP_CYCLES = amp_ctrl_pkg::RAMP_STEP_CYCLES
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic dac_sample_strobe,
  output logic sense_sample_strobe,
  output amp_ctrl_pkg::amp_controls_type controls,
  output amp_ctrl_pkg::level_status_type level_status
);
  import amp_ctrl_pkg::*;

  logic [7:0] amp_sense_config_r, amp_sense_config_nxt;
  logic [7:0] converter_config_r, converter_config_nxt;
  logic [7:0] converter_level_setting_r, converter_level_setting_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [7:0] applied_level_r, applied_level_nxt;
  logic [15:0] ramp_count_r, ramp_count_nxt;
  logic [2:0] sense_count_r, sense_count_nxt;
  logic sense_strobe_r, sense_strobe_nxt;
  rate_range_type rate_range_r, rate_range_nxt;
  amp_controls_type controls_r, controls_nxt;

  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] a, input logic [7:0] b,
                                          input logic [7:0] c);
    case (addr)
      AMP_SENSE_CONFIG_OFFSET: read_mux = a;
      CONVERTER_CONFIG_OFFSET: read_mux = b;
      CONVERTER_LEVEL_SETTING_OFFSET: read_mux = c;
      default: read_mux = UNMAPPED_READ_VALUE;
    endcase
  endfunction

  // register port: writes land next edge, reads answer one cycle later
  always_comb
  begin
    amp_sense_config_nxt = amp_sense_config_r;
    converter_config_nxt = converter_config_r;
    converter_level_setting_nxt = converter_level_setting_r;
    // reserved bits are kept as written
    if (reg_write)
    begin
      case (reg_addr)
        AMP_SENSE_CONFIG_OFFSET: amp_sense_config_nxt = reg_wdata;
        CONVERTER_CONFIG_OFFSET: converter_config_nxt = reg_wdata;
        CONVERTER_LEVEL_SETTING_OFFSET: converter_level_setting_nxt = reg_wdata;
        default: amp_sense_config_nxt = amp_sense_config_r;
      endcase
    end
    rvalid_nxt = reg_read;
    rdata_nxt = reg_read ? read_mux(reg_addr, amp_sense_config_r, converter_config_r, converter_level_setting_r)
                         : rdata_r;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      amp_sense_config_r <= AMP_SENSE_CONFIG_RESET;
      converter_config_r <= CONVERTER_CONFIG_RESET;
      converter_level_setting_r <= CONVERTER_LEVEL_SETTING_RESET;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      amp_sense_config_r <= amp_sense_config_nxt;
      converter_config_r <= converter_config_nxt;
      converter_level_setting_r <= converter_level_setting_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // rate range: a reserved code leaves the last legal range in force
  always_comb
  begin
    rate_range_nxt = rate_range_r;
    if (converter_config_r[CONVERTER_RATE_RANGE_LSB +: 3] <= 3'h4)
    begin
      rate_range_nxt = rate_range_type'(converter_config_r[CONVERTER_RATE_RANGE_LSB +: 3]);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rate_range_r <= RATE_32_48K;
    end
    else
    begin
      rate_range_r <= rate_range_nxt;
    end
  end

  // decoded control levels, registered so outputs never glitch
  always_comb
  begin
    controls_nxt.sense_rate_divisor = amp_sense_config_r[SENSE_RATE_DIVISOR_LSB +: 2];
    controls_nxt.sense_highpass_enable = amp_sense_config_r[SENSE_HIGHPASS_ENABLE_BIT];
    controls_nxt.edge_rate_select = amp_sense_config_r[EDGE_RATE_SELECT_BIT];
    controls_nxt.analog_gain_mapping = amp_sense_config_r[ANALOG_GAIN_MAPPING_BIT];
    controls_nxt.immediate_level_change = converter_config_r[IMMEDIATE_LEVEL_CHANGE_BIT];
    controls_nxt.converter_mute = converter_config_r[CONVERTER_MUTE_BIT];
    controls_nxt.converter_highpass_enable = converter_config_r[CONVERTER_HIGHPASS_ENABLE_BIT];
    controls_nxt.converter_low_power = converter_config_r[CONVERTER_LOW_POWER_BIT];
    controls_nxt.oversampling_ratio = converter_config_r[CONVERTER_LOW_POWER_BIT] ? LOW_POWER_OVERSAMPLING
                                                                                  : NORMAL_OVERSAMPLING;
    // next value keeps the range in step with the other control fields
    controls_nxt.converter_rate_range = rate_range_nxt;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      controls_r.sense_rate_divisor <= AMP_SENSE_CONFIG_RESET[SENSE_RATE_DIVISOR_LSB +: 2];
      controls_r.sense_highpass_enable <= AMP_SENSE_CONFIG_RESET[SENSE_HIGHPASS_ENABLE_BIT];
      controls_r.edge_rate_select <= AMP_SENSE_CONFIG_RESET[EDGE_RATE_SELECT_BIT];
      controls_r.analog_gain_mapping <= AMP_SENSE_CONFIG_RESET[ANALOG_GAIN_MAPPING_BIT];
      controls_r.immediate_level_change <= CONVERTER_CONFIG_RESET[IMMEDIATE_LEVEL_CHANGE_BIT];
      controls_r.converter_mute <= CONVERTER_CONFIG_RESET[CONVERTER_MUTE_BIT];
      controls_r.converter_highpass_enable <= CONVERTER_CONFIG_RESET[CONVERTER_HIGHPASS_ENABLE_BIT];
      controls_r.converter_low_power <= CONVERTER_CONFIG_RESET[CONVERTER_LOW_POWER_BIT];
      controls_r.oversampling_ratio <= LOW_POWER_OVERSAMPLING;
      controls_r.converter_rate_range <= RATE_32_48K;
    end
    else
    begin
      controls_r <= controls_nxt;
    end
  end

  // level ramp: soft mode walks one code per interval toward the target
  always_comb
  begin
    applied_level_nxt = applied_level_r;
    ramp_count_nxt = ramp_count_r;
    if (converter_config_r[IMMEDIATE_LEVEL_CHANGE_BIT])
    begin
      applied_level_nxt = converter_level_setting_r;
      ramp_count_nxt = 16'h0000;
    end
    else if (applied_level_r == converter_level_setting_r)
    begin
      ramp_count_nxt = 16'h0000;
    end
    else if (ramp_count_r >= 16'(RAMP_CYCLES - 1))
    begin
      ramp_count_nxt = 16'h0000;
      // the ramp never lands on the all-ones code early; it only reaches it as the target
      if (applied_level_r < converter_level_setting_r)
      begin
        applied_level_nxt = applied_level_r + 8'h01;
      end
      else
      begin
        applied_level_nxt = applied_level_r - 8'h01;
      end
    end
    else
    begin
      ramp_count_nxt = ramp_count_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      applied_level_r <= CONVERTER_LEVEL_SETTING_RESET;
      ramp_count_r <= 16'h0000;
    end
    else
    begin
      applied_level_r <= applied_level_nxt;
      ramp_count_r <= ramp_count_nxt;
    end
  end

  // sense strobe: every 1st, 2nd, 4th or 8th converter sample
  always_comb
  begin
    sense_count_nxt = sense_count_r;
    sense_strobe_nxt = 1'b0;
    if (dac_sample_strobe)
    begin
      case (amp_sense_config_r[SENSE_RATE_DIVISOR_LSB +: 2])
        2'h0: sense_strobe_nxt = 1'b1;
        2'h1: sense_strobe_nxt = (sense_count_r[0] == 1'b0);
        2'h2: sense_strobe_nxt = (sense_count_r[1:0] == 2'h0);
        2'h3: sense_strobe_nxt = (sense_count_r == 3'h0);
        default: sense_strobe_nxt = 1'b1;
      endcase
      sense_count_nxt = sense_count_r + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sense_count_r <= 3'h0;
      sense_strobe_r <= 1'b0;
    end
    else
    begin
      sense_count_r <= sense_count_nxt;
      sense_strobe_r <= sense_strobe_nxt;
    end
  end

  level_decode level_decode_inst
  (
    .clk(clk),
    .resetn(resetn),
    .level_code(applied_level_r),
    .mute_request(converter_config_r[CONVERTER_MUTE_BIT]),
    .status(level_status)
  );

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign sense_sample_strobe = sense_strobe_r;
  assign controls = controls_r;
endmodule // amp_dac_control_regs
`default_nettype wire

// ---- design/amp_ctrl_pkg.sv ----
// constants and carrier types for the amplifier/converter control register bank
// assumes a single 100 MHz clock and a byte-wide register port in the same domain
`default_nettype none
package amp_ctrl_pkg;
  localparam logic [7:0] AMP_SENSE_CONFIG_OFFSET = 8'h01;
  localparam logic [7:0] CONVERTER_CONFIG_OFFSET = 8'h02;
  localparam logic [7:0] CONVERTER_LEVEL_SETTING_OFFSET = 8'h03;
  localparam logic [7:0] AMP_SENSE_CONFIG_RESET = 8'h09;
  localparam logic [7:0] CONVERTER_CONFIG_RESET = 8'h32;
  localparam logic [7:0] CONVERTER_LEVEL_SETTING_RESET = 8'h40;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
  // field positions in amp_sense_config
  localparam int SENSE_RATE_DIVISOR_LSB = 4;
  localparam int SENSE_HIGHPASS_ENABLE_BIT = 3;
  localparam int EDGE_RATE_SELECT_BIT = 2;
  localparam int ANALOG_GAIN_MAPPING_BIT = 0;
  // field positions in converter_config
  localparam int IMMEDIATE_LEVEL_CHANGE_BIT = 7;
  localparam int CONVERTER_MUTE_BIT = 6;
  localparam int CONVERTER_HIGHPASS_ENABLE_BIT = 5;
  localparam int CONVERTER_LOW_POWER_BIT = 4;
  localparam int CONVERTER_RATE_RANGE_LSB = 0;
  // level code meaning and oversampling ratios
  localparam logic [7:0] UNITY_LEVEL_CODE = 8'h40;
  localparam logic [7:0] FULL_MUTE_LEVEL_CODE = 8'hFF;
  localparam logic [7:0] LOW_POWER_OVERSAMPLING = 8'h40;
  localparam logic [7:0] NORMAL_OVERSAMPLING = 8'h80;
  // soft ramp pacing: one code step per interval
  localparam int CLK_PERIOD_NS = 10;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    RATE_8_12K = 3'h0,
    RATE_16_24K = 3'h1,
    RATE_32_48K = 3'h2,
    RATE_64_96K = 3'h3,
    RATE_128_192K = 3'h4
  } rate_range_type;

  typedef struct packed {
    logic [1:0] sense_rate_divisor;
    logic sense_highpass_enable;
    logic edge_rate_select;
    logic analog_gain_mapping;
    logic immediate_level_change;
    logic converter_mute;
    logic converter_highpass_enable;
    logic converter_low_power;
    logic [7:0] oversampling_ratio;
    rate_range_type converter_rate_range;
  } amp_controls_type;

  typedef struct packed {
    logic [7:0] applied_level;
    logic signed [8:0] gain_steps;
    logic output_silenced;
  } level_status_type;
endpackage
`default_nettype wire

// ---- design/level_decode.sv ----
// maps an applied attenuation_level code to signed gain steps and a silence flag
// assumes the code comes from logic on the same clock
`default_nettype none
module level_decode
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] level_code,
  input wire logic mute_request,
  output amp_ctrl_pkg::level_status_type status
);
  import amp_ctrl_pkg::*;

  level_status_type status_r;
  level_status_type status_nxt;

  // gain in 0.375 dB units: +64 at code 0, 0 at unity, -190 at code 0xFE
  function automatic logic signed [8:0] steps_of(input logic [7:0] code);
    steps_of = $signed({1'b0, UNITY_LEVEL_CODE}) - $signed({1'b0, code});
  endfunction

  always_comb
  begin
    status_nxt.applied_level = level_code;
    status_nxt.gain_steps = steps_of(level_code);
    // all-ones silences rather than one more step
    status_nxt.output_silenced = mute_request || (level_code == FULL_MUTE_LEVEL_CODE);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_r.applied_level <= CONVERTER_LEVEL_SETTING_RESET;
      status_r.gain_steps <= 9'sh000;
      status_r.output_silenced <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  assign status = status_r;
endmodule // level_decode
`default_nettype wire

// ---- testbench/amp_dac_control_regs_asserts.sv ----
// checker for the control register bank: port timing and field mapping
// assumes it is bound to amp_dac_control_regs and sees only its ports
`default_nettype none
module amp_dac_control_regs_asserts
#(
  parameter int RAMP_CYCLES = 2
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic dac_sample_strobe,
  input wire logic sense_sample_strobe,
  input wire amp_ctrl_pkg::amp_controls_type controls,
  input wire amp_ctrl_pkg::level_status_type level_status
);
  import amp_ctrl_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_wr_sense;
    reg_write && reg_addr == AMP_SENSE_CONFIG_OFFSET;
  endsequence
  sequence s_wr_conv;
    reg_write && reg_addr == CONVERTER_CONFIG_OFFSET;
  endsequence
  property p_read_answer;
    reg_read |=> reg_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_sense_every;
    dac_sample_strobe && controls.sense_rate_divisor == 2'h0 && $stable(controls.sense_rate_divisor)
      && !$past(reg_write && reg_addr == AMP_SENSE_CONFIG_OFFSET) |=> sense_sample_strobe;
  endproperty
  a_sense_every: assert property (p_sense_every)
    else $error("sense strobe missing at divisor 1");
  property p_sense_quiet;
    !dac_sample_strobe |=> !sense_sample_strobe;
  endproperty
  a_sense_quiet: assert property (p_sense_quiet)
    else $error("sense strobe without converter strobe");
  property p_sense_cfg;
    s_wr_sense |-> ##2 {controls.sense_rate_divisor, controls.sense_highpass_enable,
      controls.edge_rate_select, controls.analog_gain_mapping} == {$past(reg_wdata[5:2], 2), $past(reg_wdata[0], 2)};
  endproperty
  a_sense_cfg: assert property (p_sense_cfg)
    else $error("sense config fields wrong");
  property p_conv_flags;
    s_wr_conv |-> ##2 {controls.immediate_level_change, controls.converter_mute,
      controls.converter_highpass_enable, controls.converter_low_power} == $past(reg_wdata[7:4], 2);
  endproperty
  a_conv_flags: assert property (p_conv_flags)
    else $error("converter flags wrong");
  property p_osr;
    controls.oversampling_ratio == (controls.converter_low_power ? 8'h40 : 8'h80);
  endproperty
  a_osr: assert property (p_osr)
    else $error("oversampling ratio wrong");
  property p_rate_legal;
    s_wr_conv ##0 reg_wdata[2:0] <= 3'h4 |-> ##2 controls.converter_rate_range == $past(reg_wdata[2:0], 2);
  endproperty
  a_rate_legal: assert property (p_rate_legal)
    else $error("rate range wrong");
  property p_hard;
    controls.immediate_level_change && reg_write && reg_addr == CONVERTER_LEVEL_SETTING_OFFSET
      && !$past(reg_write && reg_addr == CONVERTER_CONFIG_OFFSET)
      |-> ##3 level_status.applied_level == $past(reg_wdata, 3);
  endproperty
  a_hard: assert property (p_hard)
    else $error("level not applied at once");
  property p_soft_step;
    !controls.immediate_level_change [*4] ##0 $changed(level_status.applied_level)
      |-> 8'(level_status.applied_level - $past(level_status.applied_level)) inside {8'h01, 8'hFF};
  endproperty
  a_soft_step: assert property (p_soft_step)
    else $error("soft level step not one code");
  property p_gain;
    level_status.gain_steps == $signed(9'h040 - {1'b0, level_status.applied_level});
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain steps wrong");
  property p_full_mute;
    level_status.applied_level == FULL_MUTE_LEVEL_CODE |-> level_status.output_silenced;
  endproperty
  a_full_mute: assert property (p_full_mute)
    else $error("all-ones code not silent");
  property p_mute;
    controls.converter_mute [*3] |-> level_status.output_silenced;
  endproperty
  a_mute: assert property (p_mute)
    else $error("mute bit not silencing");
endmodule // amp_dac_control_regs_asserts
`default_nettype wire

// ---- testbench/tb_amp_dac_control_regs.sv ----
// self-checking bench for the control register bank
// assumes the package, design and checker files are compiled before it
`default_nettype none
module tb_amp_dac_control_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import amp_ctrl_pkg::*;
  logic clk, resetn, reg_write, reg_read, dac_sample_strobe, reg_rvalid, sense_sample_strobe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [7:0] codes [4] = '{8'h00, 8'h3F, 8'hFE, 8'hFF};
  amp_controls_type controls;
  level_status_type level_status;
  int errors = 0;
  int cmp_count = 0;
  int sense_cnt = 0;
  // short ramp pacing keeps the soft test brief
  amp_dac_control_regs #(.RAMP_CYCLES(2)) dut (.clk, .resetn, .reg_addr, .reg_write, .reg_wdata, .reg_read,
    .reg_rdata, .reg_rvalid, .dac_sample_strobe, .sense_sample_strobe, .controls, .level_status);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (sense_sample_strobe === 1'b1) sense_cnt++;
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // two spare cycles let controls and level status settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    check({1'b0, reg_rvalid}, 9'h001);
    check({1'b0, reg_rdata}, {1'b0, exp});
  endtask
  task automatic strobes(input int n);
    sense_cnt = 0;
    repeat (n)
    begin
      @(negedge clk);
      dac_sample_strobe = 1'b1;
      @(negedge clk);
      dac_sample_strobe = 1'b0;
    end
    @(negedge clk);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial
  begin
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    dac_sample_strobe = 1'b0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    rd(8'h01, 8'h09);
    rd(8'h02, 8'h32);
    rd(8'h03, 8'h40);
    rd(8'h05, 8'h00);
    check({1'b0, controls.oversampling_ratio}, 9'h040);
    $display("test reset values done");
    for (int d = 0; d < 4; d++)
    begin
      v = {2'b10, d[1:0], d[0], d[1], 1'b1, ~d[0]};
      wr(8'h01, v);
      rd(8'h01, v);
      check({4'h0, controls.sense_rate_divisor, controls.sense_highpass_enable, controls.edge_rate_select,
        controls.analog_gain_mapping}, {4'h0, v[5:2], v[0]});
      strobes(16);
      check(9'(sense_cnt), 9'(16 >> d));
    end
    $display("test sense config done");
    // reserved rate codes come last so the last legal one is 100
    for (int i = 0; i < 8; i++)
    begin
      v = {i[0], i[1], ~i[0], i[2], 1'b0, i[2:0]};
      wr(8'h02, v);
      rd(8'h02, v);
      check({5'h0, controls.immediate_level_change, controls.converter_mute, controls.converter_highpass_enable,
        controls.converter_low_power}, {5'h0, v[7:4]});
      check({1'b0, controls.oversampling_ratio}, i[2] ? 9'h040 : 9'h080);
      check({6'h0, controls.converter_rate_range}, 9'(i > 4 ? 4 : i));
    end
    $display("test converter config done");
    wr(8'h02, 8'h80);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h03, codes[k]);
      check({1'b0, level_status.applied_level}, {1'b0, codes[k]});
      check(level_status.gain_steps, 9'h040 - {1'b0, codes[k]});
      check({8'h0, level_status.output_silenced}, {8'h0, codes[k] == 8'hFF});
    end
    $display("test hard level done");
    wr(8'h03, 8'h3C);
    wr(8'h02, 8'h40);
    check({8'h0, level_status.output_silenced}, 9'h001);
    wr(8'h03, 8'h40);
    check({8'h0, level_status.applied_level == 8'h40}, 9'h000);
    repeat (20) @(negedge clk);
    check({1'b0, level_status.applied_level}, 9'h040);
    wr(8'h02, 8'h00);
    check({8'h0, level_status.output_silenced}, 9'h000);
    $display("test soft level and mute done");
    // mid-run reset must restore every field, level included
    wr(8'h02, 8'h80);
    wr(8'h03, 8'h10);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    rd(8'h01, 8'h09);
    rd(8'h02, 8'h32);
    rd(8'h03, 8'h40);
    check({6'h0, controls.converter_rate_range}, 9'h002);
    check({5'h0, controls.immediate_level_change, controls.converter_mute, controls.converter_highpass_enable,
      controls.converter_low_power}, 9'h003);
    check({1'b0, level_status.applied_level}, 9'h040);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule // tb_amp_dac_control_regs
bind amp_dac_control_regs amp_dac_control_regs_asserts #(.RAMP_CYCLES(RAMP_CYCLES)) chk (.clk(clk),
  .resetn(resetn), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .dac_sample_strobe(dac_sample_strobe),
  .sense_sample_strobe(sense_sample_strobe), .controls(controls), .level_status(level_status));
`default_nettype wire
